//--- design/ass_top.sv
// Scan input selector with SAR sequencer, result buffer and AXI4-Lite registers.
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - Mask register upper sixteen bits read zero
// - Set mask bit includes input in scan
// - Bits zero to twelve select analog pins
// - Bit thirteen selects charge time unit
// - Bit fourteen reference, fifteen ground rail
// - Missing pins convert low reference voltage
// - Automatic scan steps through enabled inputs
// - Sixteen word result buffer
// - Software selects conversion trigger source
// - Ten bit successive approximation result
module ass_top #(
    parameter int PINS = 13
) (
    input wire logic sys_clk, // System clock, 10 MHz
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic [31:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [31:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic ext_trigger, // External conversion trigger pulse
    input wire logic timer_trigger, // Timer conversion trigger pulse
    output logic [3:0] analog_mux_sel, // Selected channel index
    output logic use_low_reference, // Convert low reference instead
    output logic sample_hold, // Sample switch closed
    output logic [9:0] dac_code, // SAR trial code to comparator DAC
    input wire logic comparator_out, // High when input at or above trial code
    output logic conv_done // One-cycle pulse per stored result
);
    localparam int IW = $clog2(ass_pkg::MASK_W);
    logic [15:0] scan_input_select_bits;
    logic [4:0] ctrl;
    logic [9:0] result_buf [ass_pkg::BUF_DEPTH];
    logic [3:0] buf_ptr;
    logic [3:0] chan;
    logic [9:0] sar;
    logic [3:0] bit_idx;
    logic [7:0] cnt;
    logic busy_flag;
    logic buf_full;
    ass_pkg::ass_state_t state;

    // Write channel: both halves latched in either order
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_held && w_held && !s_axi_bvalid;
    wire wr_mask = wr_go && aw_addr == ass_pkg::ADDR_SCAN_MASK;
    wire wr_ctrl = wr_go && aw_addr == ass_pkg::ADDR_CTRL;
    wire wr_ok = wr_mask || wr_ctrl;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr[7:0];
            end
            else if (wr_go)
                aw_held <= 1'b0;
            if (w_take)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (wr_go)
                w_held <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ass_pkg::RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? ass_pkg::RESP_OKAY : ass_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Trigger selection
    logic [1:0] tsel;
    assign tsel = ctrl[ass_pkg::CTRL_TSEL_HI:ass_pkg::CTRL_TSEL_LO];
    wire scan_on = ctrl[ass_pkg::CTRL_SCAN_EN];
    // An empty mask leaves the scan nothing to visit, so it is not started
    wire scan_en_ok = !scan_on || scan_input_select_bits != 16'h0000;
    wire trig = (tsel == ass_pkg::TSEL_SOFT) ? ctrl[ass_pkg::CTRL_SWTRIG] :
        (tsel == ass_pkg::TSEL_EXT) ? ext_trigger :
        (tsel == ass_pkg::TSEL_TIMER) ? timer_trigger : ctrl[ass_pkg::CTRL_AUTO];
    wire start = trig && state == ass_pkg::ASS_IDLE && scan_en_ok;
    wire sw_start = ctrl[ass_pkg::CTRL_SWTRIG] && state == ass_pkg::ASS_IDLE;

    // Upper half of the data word has no storage, so writes there vanish
    wire [15:0] next_mask = {w_strb[1] ? w_data[15:8] : scan_input_select_bits[15:8],
        w_strb[0] ? w_data[7:0] : scan_input_select_bits[7:0]};

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scan_input_select_bits <= ass_pkg::MASK_RESET;
            ctrl <= ass_pkg::CTRL_RESET;
        end
        else
        begin
            if (wr_mask)
                scan_input_select_bits <= next_mask;
            if (wr_ctrl && w_strb[0])
                ctrl <= w_data[4:0];
            else if (sw_start)
                ctrl[ass_pkg::CTRL_SWTRIG] <= 1'b0;
        end
    end

    // Read channel
    wire [7:0] ra = s_axi_araddr[7:0];
    wire rd_buf = ra >= ass_pkg::ADDR_RESULT0 && ra < ass_pkg::ADDR_RESULT0 + 8'h40;
    wire [3:0] rd_idx = 4'((ra - ass_pkg::ADDR_RESULT0) >> 2);
    wire rd_mask = ra == ass_pkg::ADDR_SCAN_MASK;
    wire rd_ctrl = ra == ass_pkg::ADDR_CTRL;
    wire rd_stat = ra == ass_pkg::ADDR_STATUS;
    wire rd_hit = rd_mask || rd_ctrl || rd_stat || rd_buf;
    wire [31:0] rd_word = rd_mask ? {16'h0000, scan_input_select_bits} :
        rd_ctrl ? {27'h0000000, ctrl} :
        rd_stat ? {22'h000000, buf_full, busy_flag, chan, buf_ptr} :
        rd_buf ? {22'h000000, result_buf[rd_idx]} : 32'h0000_0000;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ass_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? ass_pkg::RESP_OKAY : ass_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Next enabled channel above the current one, wrapping to the lowest
    function automatic logic [3:0] next_chan(input logic [15:0] m, input logic [3:0] c);
        logic [3:0] r;
        logic found;
        r = c;
        found = 1'b0;
        for (int k = 1; k <= 16; k++)
        begin
            if (!found && m[4'(int'(c) + k)])
            begin
                r = 4'(int'(c) + k);
                found = 1'b1;
            end
        end
        return r;
    endfunction
    wire [3:0] scan_next = next_chan(scan_input_select_bits, chan);

    assign analog_mux_sel = chan;
    // Channels below 13 without a bonded pin fall back to the low reference
    assign use_low_reference = int'(chan) < ass_pkg::PIN_COUNT && int'(chan) >= PINS;
    assign sample_hold = state == ass_pkg::ASS_SAMPLE;
    assign dac_code = sar;

    // Buffer words carry no reset, so they can map onto plain memory
    always_ff @(posedge sys_clk)
    begin
        if (state == ass_pkg::ASS_STORE)
            result_buf[buf_ptr] <= sar;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= ass_pkg::ASS_IDLE;
            chan <= 4'h0;
            sar <= 10'h000;
            bit_idx <= 4'h0;
            cnt <= 8'h00;
            buf_ptr <= 4'h0;
            buf_full <= 1'b0;
            conv_done <= 1'b0;
            busy_flag <= 1'b0;
        end
        else
        begin
            conv_done <= 1'b0;
            case (state)
                ass_pkg::ASS_IDLE:
                begin
                    if (start)
                    begin
                        state <= ass_pkg::ASS_SAMPLE;
                        busy_flag <= 1'b1;
                        cnt <= 8'(ass_pkg::SAMPLE_CYC - 1);
                        if (scan_on)
                            chan <= scan_next;
                    end
                end
                ass_pkg::ASS_SAMPLE:
                begin
                    if (cnt == 8'h00)
                    begin
                        state <= ass_pkg::ASS_CONVERT;
                        bit_idx <= 4'(ass_pkg::RES_W - 1);
                        sar <= 10'h200;
                    end
                    else
                        cnt <= cnt - 8'h01;
                end
                ass_pkg::ASS_CONVERT:
                begin
                    // One bit decided per clock, MSB first
                    if (!comparator_out)
                        sar[bit_idx] <= 1'b0;
                    if (bit_idx == 4'h0)
                        state <= ass_pkg::ASS_STORE;
                    else
                    begin
                        sar[bit_idx - 4'h1] <= 1'b1;
                        bit_idx <= bit_idx - 4'h1;
                    end
                end
                ass_pkg::ASS_STORE:
                begin
                    buf_ptr <= buf_ptr + 4'h1;
                    buf_full <= buf_full || buf_ptr == 4'hF;
                    conv_done <= 1'b1;
                    busy_flag <= 1'b0;
                    state <= ass_pkg::ASS_IDLE;
                end
                default:
                    state <= ass_pkg::ASS_IDLE;
            endcase
        end
    end

    a_mask_upper_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_axi_arvalid && s_axi_arready && rd_mask |=> s_axi_rdata[31:16] == 16'h0000)
        else $error("mask upper half not zero");
    a_scan_skip_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
        state == ass_pkg::ASS_SAMPLE && $past(state) == ass_pkg::ASS_IDLE && scan_on
        |-> scan_input_select_bits[chan])
        else $error("scan picked cleared input");
    a_scan_order: assert property (@(posedge sys_clk) disable iff (!rst_b)
        start && scan_on |=> chan == $past(scan_next))
        else $error("scan order wrong");
    a_mux_follows: assert property (@(posedge sys_clk) disable iff (!rst_b)
        start && scan_on && scan_next == 4'hD |=> analog_mux_sel == 4'hD && !use_low_reference)
        else $error("charge time channel replaced");
    a_sar_length: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(state == ass_pkg::ASS_CONVERT) |-> ##10 state == ass_pkg::ASS_STORE)
        else $error("conversion length wrong");
    sequence s_store;
        state == ass_pkg::ASS_STORE;
    endsequence
    a_store_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_store |=> conv_done && buf_ptr == $past(buf_ptr) + 4'h1)
        else $error("store did not advance buffer");
    a_trig_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
        start |=> state == ass_pkg::ASS_SAMPLE ##1 sample_hold)
        else $error("trigger did not start");
    a_low_ref: assert property (@(posedge sys_clk) disable iff (!rst_b)
        int'(chan) >= ass_pkg::PIN_COUNT |-> !use_low_reference)
        else $error("internal source replaced");
    a_mask_reset: assert property (@(posedge sys_clk)
        !rst_b |=> scan_input_select_bits == 16'h0000 || !rst_b || $past(wr_mask))
        else $error("mask not zero after reset");
    a_pin_map: assert property (@(posedge sys_clk) disable iff (!rst_b)
        int'(chan) < PINS |-> !use_low_reference)
        else $error("bonded pin replaced");
    a_pinless_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
        int'(chan) >= PINS && int'(chan) < ass_pkg::PIN_COUNT |-> use_low_reference)
        else $error("missing pin not replaced");
    sequence s_sample_phase;
        sample_hold ##1 sample_hold ##1 !sample_hold;
    endsequence
    a_sample_window: assert property (@(posedge sys_clk) disable iff (!rst_b)
        start |=> s_sample_phase)
        else $error("sample window wrong");
    a_mask_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_mask |=> scan_input_select_bits == $past(next_mask))
        else $error("mask write lost");
    a_unmapped_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_go && !wr_ok |=> s_axi_bresp == ass_pkg::RESP_SLVERR && $stable(scan_input_select_bits))
        else $error("unmapped write had effect");
    a_done_single: assert property (@(posedge sys_clk) disable iff (!rst_b)
        conv_done |=> !conv_done)
        else $error("done pulse too long");
    a_result_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_axi_arvalid && s_axi_arready && rd_buf |=> s_axi_rresp == ass_pkg::RESP_OKAY)
        else $error("result read refused");
    // Status reads report busy, so it must track the sequencer exactly
    a_busy_state: assert property (@(posedge sys_clk) disable iff (!rst_b)
        busy_flag == (state != ass_pkg::ASS_IDLE))
        else $error("busy flag disagrees");
endmodule

//--- include/ass_pkg.sv
// Package for the scan input selector: offsets, fields, reset values and timing.
package ass_pkg;
    localparam logic [7:0] ADDR_SCAN_MASK = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_RESULT0 = 8'h40;
    localparam int MASK_W = 16;
    localparam int RES_W = 10;
    localparam int BUF_DEPTH = 16;
    localparam int PIN_COUNT = 13;
    localparam int CH_CHARGE_TIME_MEASURE_UNIT = 13;
    localparam int CH_INTERNAL_VOLTAGE_REFERENCE = 14;
    localparam int CH_GND = 15;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam int CTRL_SCAN_EN = 0;
    localparam int CTRL_SWTRIG = 1;
    localparam int CTRL_TSEL_LO = 2;
    localparam int CTRL_TSEL_HI = 3;
    localparam int CTRL_AUTO = 4;
    localparam real SAMPLE_TIME_NS = 200.0;
    localparam real CLK_PERIOD_NS = 100.0;
    localparam int SAMPLE_CYC = (int'($ceil(SAMPLE_TIME_NS / CLK_PERIOD_NS)) < 1) ? 1 :
        int'($ceil(SAMPLE_TIME_NS / CLK_PERIOD_NS));
    localparam logic [1:0] TSEL_SOFT = 2'h0;
    localparam logic [1:0] TSEL_EXT = 2'h1;
    localparam logic [1:0] TSEL_TIMER = 2'h2;
    localparam logic [1:0] TSEL_AUTO = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ASS_IDLE = 2'b00,
        ASS_SAMPLE = 2'b01,
        ASS_CONVERT = 2'b10,
        ASS_STORE = 2'b11
    } ass_state_t;
endpackage

//--- verif/ass_analog_model.sv
// Analog source model that answers the converter comparator.
`timescale 1ns/1ps
module ass_analog_model (
    input wire logic sys_clk, // System clock
    input wire logic [159:0] levels, // Ten-bit level per channel
    input wire logic [3:0] analog_mux_sel, // Channel chosen
    input wire logic use_low_reference, // Force low reference
    input wire logic sample_hold, // Sample switch closed
    input wire logic [9:0] dac_code, // Trial code
    output logic comparator_out // High while input at or above trial
);
    logic [9:0] held;
    initial held = 10'h000;
    // Internal sources share the table, so ground must be loaded as zero
    always @(posedge sys_clk)
    begin
        if (sample_hold)
        begin
            held <= use_low_reference ? 10'h000 :
                levels[analog_mux_sel*10 +: 10];
        end
    end
    assign comparator_out = (held >= dac_code);
endmodule

//--- verif/tb_top.sv
// Self-checking bench for the scan input selector.
`timescale 1ns/1ps
module tb_top;
    localparam int PINS = 10;
    logic sys_clk = 1'b0;
    logic rst_b, awvalid, wvalid, bready, arvalid, rready, ext_t, tim_t, comp;
    logic awready, wready, bvalid, arready, rvalid, lowref, shold, done;
    logic sh_q = 1'b0;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb, sel;
    logic [1:0] bresp, rresp;
    logic [9:0] dac;
    logic [159:0] levels;
    logic [33:0] rq[$];
    logic [33:0] bq[$];
    logic [33:0] cq[$];
    int err_count = 0;
    int num_checks = 0;
    int seed = 1740;
    // Last two steps run the free-running trigger, then stop it
    int order[10] = '{3, 11, 13, 14, 15, 0, 3, 11, 13, 14};
    logic [31:0] ctl[10] = '{3, 3, 3, 3, 3, 3, 5, 9, 29, 1};
    always #50 sys_clk = ~sys_clk;
    ass_top #(.PINS(PINS)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ext_trigger(ext_t), .timer_trigger(tim_t),
        .analog_mux_sel(sel), .use_low_reference(lowref), .sample_hold(shold),
        .dac_code(dac), .comparator_out(comp), .conv_done(done));
    ass_analog_model model_u (.sys_clk(sys_clk), .levels(levels), .analog_mux_sel(sel),
        .use_low_reference(lowref), .sample_hold(shold), .dac_code(dac),
        .comparator_out(comp));
    task automatic cmp(input string what, input logic [33:0] q[$], input logic [33:0] got);
        logic [33:0] exp;
        num_checks++;
        exp = (q.size() > 0) ? q[0] : 34'h3FFFFFFFF;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_read(input logic [33:0] got);
        cmp("read", rq, got);
        void'(rq.pop_front());
    endtask
    task automatic cmp_resp(input logic [33:0] got);
        cmp("bresp", bq, got);
        void'(bq.pop_front());
    endtask
    task automatic cmp_chan(input logic [33:0] got);
        cmp("channel", cq, got);
        void'(cq.pop_front());
    endtask
    function automatic logic [33:0] chan_note(input int c);
        logic pinless;
        pinless = c >= PINS && c < ass_pkg::PIN_COUNT;
        return {29'h0, pinless, 4'(c)};
    endfunction
    always @(posedge sys_clk)
    begin
        if (rvalid && rready)
            cmp_read({rresp, rdata});
        if (bvalid && bready)
            cmp_resp({32'h0, bresp});
        if (shold && !sh_q)
            cmp_chan({29'h0, lowref, sel});
        sh_q <= shold;
    end
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_p;
        logic w_p;
        @(posedge sys_clk);
        bq.push_back({32'h0, r});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_p = 1'b1;
        w_p = 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (aw_p && awready)
            begin
                aw_p = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_p && wready)
            begin
                w_p = 1'b0;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ar_p;
        @(posedge sys_clk);
        rq.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        ar_p = 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (ar_p && arready)
            begin
                ar_p = 1'b0;
                arvalid <= 1'b0;
            end
        end
        while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (30000) @(posedge sys_clk);
        err_count++;
        close_out();
    end
    initial
    begin
        logic [9:0] v;
        int k;
        {awvalid, wvalid, bready, arvalid, rready, ext_t, tim_t} = 7'h00;
        {awaddr, wdata, araddr} = 96'h0;
        wstrb = 4'hF;
        rst_b = 1'b0;
        for (k = 0; k < 16; k++)
            levels[k*10 +: 10] = (k == 15) ? 10'h000 : 10'($random(seed));
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(32'h0, 32'h0, ass_pkg::RESP_OKAY);
        rd(32'hF0, 32'h0, ass_pkg::RESP_SLVERR);
        wr(32'hF0, 32'h1, ass_pkg::RESP_SLVERR);
        $display("test registers done");
        wr(32'h0, 32'hFFFFFFFF, ass_pkg::RESP_OKAY);
        rd(32'h0, 32'h0000FFFF, ass_pkg::RESP_OKAY);
        wr(32'h0, 32'hABCDE809, ass_pkg::RESP_OKAY);
        rd(32'h0, 32'h0000E809, ass_pkg::RESP_OKAY);
        $display("test mask done");
        // Channel 11 has no pin with PINS at 10, so it must read as zero
        for (k = 0; k < 10; k++)
        begin
            // The free-running trigger restarts by itself, so its second channel is noted now
            if (k != 9)
                cq.push_back(chan_note(order[k]));
            if (k == 8)
                cq.push_back(chan_note(order[9]));
            wr({24'h0, ass_pkg::ADDR_CTRL}, ctl[k], ass_pkg::RESP_OKAY);
            @(posedge sys_clk);
            ext_t <= (k == 6);
            tim_t <= (k == 7);
            @(posedge sys_clk);
            ext_t <= 1'b0;
            tim_t <= 1'b0;
            repeat (100) @(posedge sys_clk) if (done === 1'b1) break;
            v = (order[k] >= PINS && order[k] < 13) ? 10'h000 : levels[order[k]*10 +: 10];
            rd({24'h0, ass_pkg::ADDR_RESULT0} + 32'(4 * k), {22'h0, v},
                ass_pkg::RESP_OKAY);
        end
        // Ten results stored, last channel fourteen, converter idle
        rd({24'h0, ass_pkg::ADDR_STATUS}, 32'h0000_00EA, ass_pkg::RESP_OKAY);
        $display("test scan done");
        repeat (4) @(posedge sys_clk);
        close_out();
    end
endmodule
